// *** design/mq_flag_pkg.sv ***
// Constants, types and register map for the multi-queue flag generator.
package mq_flag_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NQ  = 4;
    localparam int QW  = 2;
    localparam int IDW = 3;
    localparam int CW  = 20;
    localparam int DW  = 16;
    localparam int AW  = 4;
    localparam int RW  = 32;

    // ------------------------------------------------------------------
    // Bus-matching setups, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        BM_36_36 = 5'h01,
        BM_18_36 = 5'h02,
        BM_9_36  = 5'h04,
        BM_36_18 = 5'h08,
        BM_36_9  = 5'h10
    } bus_mode_t;

    typedef struct packed {
        logic [DW-1:0] depth;
        logic [DW-1:0] offset;
    } queue_cfg_t;

    // ------------------------------------------------------------------
    // Register word addresses
    // ------------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_CONFIG  = 4'h0;
    localparam logic [AW-1:0] ADDR_STATUS  = 4'h1;
    localparam logic [AW-1:0] ADDR_DEPTH0  = 4'h2;
    localparam logic [AW-1:0] ADDR_OFFSET0 = 4'h6;
    localparam logic [AW-1:0] ADDR_COUNT0  = 4'hA;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CFG_MODE_LSB   = 0;
    localparam int CFG_PACKET_BIT = 5;
    localparam int CFG_DEFAULT_BIT = 6;
    localparam int ST_VALID_LSB   = 0;
    localparam int ST_FULL_LSB    = 4;
    localparam int ST_AFULL_LSB   = 8;
    localparam int ST_STRAP_BIT   = 12;

    localparam logic [DW-1:0] DEPTH_RESET        = 16'h0100;
    localparam logic [DW-1:0] OFFSET_RESET       = 16'h0008;
    localparam logic [DW-1:0] DEFAULT_OFFSET_LOW  = 16'h0008;
    localparam logic [DW-1:0] DEFAULT_OFFSET_HIGH = 16'h0080;

    // ------------------------------------------------------------------
    // Flag latencies in MCLK cycles
    // ------------------------------------------------------------------
    localparam int OV_ASSERT_CYCLES    = 1;
    localparam int FULL_RELEASE_CYCLES = 1;
    localparam int AF_ASSERT_CYCLES    = 2;

endpackage

// *** design/flag_threshold.sv ***
// Full and almost-full write counts for one queue.
`timescale 1ns/1ps
module flag_threshold (
    // Setup
    input  wire mq_flag_pkg::bus_mode_t      mode,
    input  wire mq_flag_pkg::queue_cfg_t     cfg,
    input  wire logic                        fwft,
    // Boundaries in input words
    output logic [mq_flag_pkg::CW-1:0]       full_thr,
    output logic [mq_flag_pkg::CW-1:0]       af_thr
);
    logic                        out36;
    logic                        narrow_in;
    logic [mq_flag_pkg::CW-1:0]  full_words;
    logic [mq_flag_pkg::CW-1:0]  af_words;
    logic [mq_flag_pkg::CW-1:0]  af_base;
    logic [mq_flag_pkg::CW-1:0]  off_words;

    always_comb begin
        out36     = (mode == mq_flag_pkg::BM_36_36) || (mode == mq_flag_pkg::BM_18_36) ||
                    (mode == mq_flag_pkg::BM_9_36);
        narrow_in = (mode == mq_flag_pkg::BM_18_36) || (mode == mq_flag_pkg::BM_9_36);
        off_words = {4'h0, cfg.offset};
        // With 36-bit output the output register adds one slot when it was primed at the first write.
        full_words = {4'h0, cfg.depth} + {19'h00000, out36 & fwft}; // R5 R6
        // Narrow input always counts the output register toward almost full.
        af_base = {4'h0, cfg.depth} + {19'h00000, out36 & (narrow_in | fwft)}; // R11 R12 R13
        af_words = (off_words > af_base) ? 20'h00000 : af_base - off_words; // R21
        case (mode)
            mq_flag_pkg::BM_18_36: begin
                full_thr = {full_words[18:0], 1'b0}; // R7
                af_thr   = {af_words[18:0], 1'b0};
            end
            mq_flag_pkg::BM_9_36: begin
                full_thr = {full_words[17:0], 2'b00}; // R8
                af_thr   = {af_words[17:0], 2'b00};
            end
            default: begin
                full_thr = full_words;
                af_thr   = af_words;
            end
        endcase
    end
endmodule

// *** design/queue_occupancy.sv ***
// Occupancy counter for one queue, in input-bus words.
`timescale 1ns/1ps
module queue_occupancy (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // Setup
    input  wire mq_flag_pkg::bus_mode_t      mode,
    // Events
    input  wire logic                        wr,
    input  wire logic                        rd,
    input  wire logic                        rd_sel,
    // State
    output logic [mq_flag_pkg::CW-1:0]       count,
    output logic                             fwft,
    output logic                             nonempty,
    output logic                             next_nonempty
);
    logic [mq_flag_pkg::CW-1:0] next_count;
    logic [1:0]                 rsub;
    logic [1:0]                 next_rsub;
    logic                       next_fwft;
    logic [mq_flag_pkg::CW-1:0] units;
    logic [1:0]                 last_sub;
    logic [mq_flag_pkg::CW-1:0] dec;

    always_comb begin
        case (mode)
            mq_flag_pkg::BM_18_36: units = 20'h00002;
            mq_flag_pkg::BM_9_36:  units = 20'h00004;
            default:               units = 20'h00001;
        endcase
        case (mode)
            mq_flag_pkg::BM_36_18: last_sub = 2'h1;
            mq_flag_pkg::BM_36_9:  last_sub = 2'h3;
            default:               last_sub = 2'h0;
        endcase
        dec       = 20'h00000;
        next_rsub = rsub;
        if (rd) begin
            if (rsub == last_sub) begin
                dec       = units;
                next_rsub = 2'h0;
            end else begin
                next_rsub = rsub + 2'h1;
            end
        end
        next_count    = count + {19'h00000, wr} - dec;
        next_nonempty = next_count >= units;
        if (next_count == 20'h00000) begin
            next_fwft = 1'b0;
        end else if (wr && count == 20'h00000) begin
            next_fwft = rd_sel; // R1
        end else begin
            next_fwft = fwft;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count    <= 20'h00000;
            rsub     <= 2'h0;
            fwft     <= 1'b0;
            nonempty <= 1'b0;
        end else begin
            count    <= next_count;
            rsub     <= next_rsub;
            fwft     <= next_fwft;
            nonempty <= next_nonempty;
        end
    end
endmodule

// *** design/multiqueue_flags.sv ***
// Output-valid, full and almost-full flag generation for a four-queue FIFO.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

// Summary of operation
// (R1) Output valid goes low after the first write into an empty queue.
// (R2) Output valid asserts one clock after the write.
// (R3) Output valid releases on the very edge of the emptying read.
// (R4) Packet mode keeps the same output valid timing, only for 36-to-36.
// (R5) 36-to-36 with read port on the queue: full after depth plus one writes.
// (R6) Full after depth writes when write-only selected or output is narrow.
// (R7) 18-bit input: full after twice depth-plus-one, or twice depth.
// (R8) 9-bit input: full after four times depth-plus-one, or four times depth.
// (R9) Full asserts on the edge of the filling write.
// (R10) Full releases one clock after a read frees space.
// (R11) 36-to-36 almost full at depth plus one minus offset, or depth minus offset.
// (R12) 36-bit input to narrow output: almost full at depth minus offset.
// (R13) Narrow input: almost full at depth plus one minus offset, times two or four.
// (R14) Default offset is 8 or 128 from the strap caught after reset.
// (R15) Almost full asserts two clocks after the boundary write.
// (R16) Almost full releases after a read through the same pipeline.
// (R17) Almost-full bus bits assert two clocks after the boundary write.
// (R18) A write queue switch may add one clock to a bus bit change.
// (R19) Almost full shows the write-selected queue from the second edge on.
// (R20) Output valid is driven only when the read ID bits match.
// (R21) Flags are active low; counts in input-bus words; per-queue offsets.
module multiqueue_flags (
    // Clock and reset
    input  wire logic                                  MCLK,
    input  wire logic                                  RST_B,
    // Write port
    input  wire logic                                  WRITE_ENABLE,
    input  wire logic [mq_flag_pkg::QW-1:0]            WRITE_QUEUE_SELECT,
    // Read port
    input  wire logic                                  READ_ENABLE,
    input  wire logic [mq_flag_pkg::IDW+mq_flag_pkg::QW-1:0] READ_QUEUE_SELECT,
    input  wire logic [mq_flag_pkg::IDW-1:0]           EXPANSION_ID_INPUT,
    input  wire logic                                  DEFAULT_OFFSET_SELECT,
    // Register port
    input  wire logic [mq_flag_pkg::AW-1:0]            REG_ADDR,
    input  wire logic [mq_flag_pkg::RW-1:0]            REG_WDATA,
    input  wire logic                                  REG_WR,
    input  wire logic                                  REG_RD,
    output logic [mq_flag_pkg::RW-1:0]                 REG_RDATA,
    // Flags
    output logic                                       OUTPUT_VALID_N_O,
    output logic                                       OUTPUT_VALID_N_OE,
    output logic                                       FULL_FLAG_N,
    output logic                                       ALMOST_FULL_N,
    output logic [mq_flag_pkg::NQ-1:0]                 ALMOST_FULL_BUS
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    mq_flag_pkg::bus_mode_t   mode;
    mq_flag_pkg::bus_mode_t   next_mode;
    logic                     packet_mode;
    logic                     next_packet_mode;
    logic                     use_default;
    logic                     next_use_default;
    mq_flag_pkg::queue_cfg_t  qcfg [mq_flag_pkg::NQ];
    mq_flag_pkg::queue_cfg_t  next_qcfg [mq_flag_pkg::NQ];
    mq_flag_pkg::queue_cfg_t  eff_cfg [mq_flag_pkg::NQ];
    logic [mq_flag_pkg::RW-1:0] next_rdata;
    logic                     strap_done;
    logic                     next_strap_done;
    logic                     strap_val;
    logic                     next_strap_val;

    logic [mq_flag_pkg::CW-1:0] count [mq_flag_pkg::NQ];
    logic [mq_flag_pkg::CW-1:0] full_thr [mq_flag_pkg::NQ];
    logic [mq_flag_pkg::CW-1:0] af_thr [mq_flag_pkg::NQ];
    logic [mq_flag_pkg::NQ-1:0] fwft;
    logic [mq_flag_pkg::NQ-1:0] nonempty;
    logic [mq_flag_pkg::NQ-1:0] next_nonempty;
    logic [mq_flag_pkg::NQ-1:0] wr_q;
    logic [mq_flag_pkg::NQ-1:0] rd_q;
    logic [mq_flag_pkg::NQ-1:0] full_cmp;
    logic [mq_flag_pkg::NQ-1:0] fills;
    logic [mq_flag_pkg::NQ-1:0] af_cmp;
    logic [mq_flag_pkg::NQ-1:0] af_stage;
    logic [mq_flag_pkg::NQ-1:0] next_af_stage;
    logic [mq_flag_pkg::QW-1:0] wsel_q;
    logic [mq_flag_pkg::QW-1:0] rq;
    logic                     id_match;
    logic                     next_ov_n;
    logic                     next_full_n;
    logic                     next_af_n;
    logic [mq_flag_pkg::NQ-1:0] next_af_bus;
    logic                     af_cmp_w;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always_comb begin
        next_mode        = mode;
        next_packet_mode = packet_mode;
        next_use_default = use_default;
        next_qcfg        = qcfg;
        next_rdata       = 32'h00000000;
        if (REG_WR) begin
            if (REG_ADDR == mq_flag_pkg::ADDR_CONFIG) begin
                next_mode        = mq_flag_pkg::bus_mode_t'(REG_WDATA[mq_flag_pkg::CFG_MODE_LSB +: 5]);
                next_packet_mode = REG_WDATA[mq_flag_pkg::CFG_PACKET_BIT];
                next_use_default = REG_WDATA[mq_flag_pkg::CFG_DEFAULT_BIT];
            end
            for (int i = 0; i < mq_flag_pkg::NQ; i++) begin
                if (REG_ADDR == mq_flag_pkg::ADDR_DEPTH0 + 4'(i)) begin
                    next_qcfg[i].depth = REG_WDATA[mq_flag_pkg::DW-1:0];
                end
                if (REG_ADDR == mq_flag_pkg::ADDR_OFFSET0 + 4'(i)) begin
                    next_qcfg[i].offset = REG_WDATA[mq_flag_pkg::DW-1:0];
                end
            end
        end
        if (REG_RD) begin
            if (REG_ADDR == mq_flag_pkg::ADDR_CONFIG) begin
                next_rdata[mq_flag_pkg::CFG_MODE_LSB +: 5]  = mode;
                next_rdata[mq_flag_pkg::CFG_PACKET_BIT]     = packet_mode;
                next_rdata[mq_flag_pkg::CFG_DEFAULT_BIT]    = use_default;
            end
            if (REG_ADDR == mq_flag_pkg::ADDR_STATUS) begin
                next_rdata[mq_flag_pkg::ST_VALID_LSB +: 4] = nonempty;
                next_rdata[mq_flag_pkg::ST_FULL_LSB +: 4]  = full_cmp;
                next_rdata[mq_flag_pkg::ST_AFULL_LSB +: 4] = af_stage;
                next_rdata[mq_flag_pkg::ST_STRAP_BIT]      = strap_val;
            end
            for (int i = 0; i < mq_flag_pkg::NQ; i++) begin
                if (REG_ADDR == mq_flag_pkg::ADDR_DEPTH0 + 4'(i)) begin
                    next_rdata[mq_flag_pkg::DW-1:0] = qcfg[i].depth;
                end
                if (REG_ADDR == mq_flag_pkg::ADDR_OFFSET0 + 4'(i)) begin
                    next_rdata[mq_flag_pkg::DW-1:0] = qcfg[i].offset;
                end
                if (REG_ADDR == mq_flag_pkg::ADDR_COUNT0 + 4'(i)) begin
                    next_rdata[mq_flag_pkg::CW-1:0] = count[i];
                end
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            mode        <= mq_flag_pkg::BM_36_36;
            packet_mode <= 1'b0;
            use_default <= 1'b1;
            REG_RDATA   <= 32'h00000000;
            for (int i = 0; i < mq_flag_pkg::NQ; i++) begin
                qcfg[i] <= '{depth: mq_flag_pkg::DEPTH_RESET, offset: mq_flag_pkg::OFFSET_RESET};
            end
        end else begin
            mode        <= next_mode;
            packet_mode <= next_packet_mode;
            use_default <= next_use_default;
            REG_RDATA   <= next_rdata;
            qcfg        <= next_qcfg;
        end
    end

    // ------------------------------------------------------------------
    // Default offset strap, caught on the first edge after reset
    // ------------------------------------------------------------------
    always_comb begin
        next_strap_done = 1'b1;
        next_strap_val  = strap_done ? strap_val : DEFAULT_OFFSET_SELECT; // R14
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_done <= 1'b0;
            strap_val  <= 1'b0;
        end else begin
            strap_done <= next_strap_done;
            strap_val  <= next_strap_val;
        end
    end

    // ------------------------------------------------------------------
    // Per-queue occupancy and boundaries
    // ------------------------------------------------------------------
    assign rq       = READ_QUEUE_SELECT[mq_flag_pkg::QW-1:0];
    assign id_match = READ_QUEUE_SELECT[mq_flag_pkg::IDW+mq_flag_pkg::QW-1:mq_flag_pkg::QW] == EXPANSION_ID_INPUT;

    for (genvar g = 0; g < mq_flag_pkg::NQ; g++) begin : gen_queue
        always_comb begin
            eff_cfg[g].depth  = qcfg[g].depth;
            eff_cfg[g].offset = !use_default ? qcfg[g].offset :
                                strap_val ? mq_flag_pkg::DEFAULT_OFFSET_HIGH :
                                mq_flag_pkg::DEFAULT_OFFSET_LOW; // R14 R21
        end
        assign full_cmp[g] = count[g] >= full_thr[g];
        assign af_cmp[g]   = count[g] >= af_thr[g];
        assign wr_q[g]     = WRITE_ENABLE && (WRITE_QUEUE_SELECT == g) && !full_cmp[g];
        assign rd_q[g]     = READ_ENABLE && id_match && (rq == g) && nonempty[g];
        assign fills[g]    = wr_q[g] && (count[g] + 20'h00001 >= full_thr[g]); // R9

        queue_occupancy u_occ (
            .clk           (MCLK),
            .rst_b         (RST_B),
            .mode          (mode),
            .wr            (wr_q[g]),
            .rd            (rd_q[g]),
            .rd_sel        (id_match && (rq == g)), // R1
            .count         (count[g]),
            .fwft          (fwft[g]),
            .nonempty      (nonempty[g]),
            .next_nonempty (next_nonempty[g])
        );

        flag_threshold u_thr (
            .mode     (mode),
            .cfg      (eff_cfg[g]),
            .fwft     (fwft[g]),
            .full_thr (full_thr[g]),
            .af_thr   (af_thr[g])
        );
    end

    // ------------------------------------------------------------------
    // Flag pipelines
    // ------------------------------------------------------------------
    always_comb begin
        // Packet mode only differs in skew, which a single clock hides.
        next_ov_n = rd_q[rq] ? !next_nonempty[rq] : !nonempty[rq]; // R2 R3 R4
        next_full_n = fills[WRITE_QUEUE_SELECT] ? 1'b0 : !full_cmp[WRITE_QUEUE_SELECT]; // R9 R10
        // Every queue keeps its status; the first stage takes it off the counter.
        next_af_stage = af_cmp; // R15 R16
        next_af_n     = !af_stage[wsel_q]; // R19
        // A queue switch adds no cycle here, the bus follows its own queue.
        next_af_bus = ~af_stage; // R17 R18
        af_cmp_w    = af_cmp[WRITE_QUEUE_SELECT];
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            OUTPUT_VALID_N_O  <= 1'b1;
            OUTPUT_VALID_N_OE <= 1'b0;
            FULL_FLAG_N       <= 1'b1;
            ALMOST_FULL_N     <= 1'b1;
            ALMOST_FULL_BUS   <= 4'hF;
            af_stage          <= 4'h0;
            wsel_q            <= 2'h0;
        end else begin
            OUTPUT_VALID_N_O  <= next_ov_n;
            OUTPUT_VALID_N_OE <= id_match; // R20
            FULL_FLAG_N       <= next_full_n;
            ALMOST_FULL_N     <= next_af_n;
            ALMOST_FULL_BUS   <= next_af_bus;
            af_stage          <= next_af_stage;
            wsel_q            <= WRITE_QUEUE_SELECT;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);

    chk_ov_assert: assert property ( // R2
        (wr_q[rq] && !nonempty[rq] && next_nonempty[rq] && id_match) ##1 ($stable(rq) && !READ_ENABLE)
        |=> !OUTPUT_VALID_N_O)
        else $error("output valid missed one clock after first write");

    chk_ov_release: assert property ( // R3
        (rd_q[rq] && !next_nonempty[rq]) |=> OUTPUT_VALID_N_O)
        else $error("output valid not released on emptying read");

    chk_full_assert: assert property ( // R9
        fills[WRITE_QUEUE_SELECT] |=> !FULL_FLAG_N)
        else $error("full flag not asserted on filling write");

    chk_full_release: assert property ( // R10
        (!full_cmp[WRITE_QUEUE_SELECT] && !fills[WRITE_QUEUE_SELECT]) |=> FULL_FLAG_N)
        else $error("full flag held with space free");

    chk_full_depth: assert property ( // R5
        (mode == mq_flag_pkg::BM_36_36 && fwft[0]) |-> full_thr[0] == {4'h0, eff_cfg[0].depth} + 20'h00001)
        else $error("full boundary wrong for primed queue");

    chk_paf_delay: assert property ( // R15
        af_cmp_w |-> ##2 !ALMOST_FULL_N)
        else $error("almost full not low two clocks after boundary");

    chk_paf_switch: assert property ( // R19
        ##2 (ALMOST_FULL_N == ALMOST_FULL_BUS[$past(WRITE_QUEUE_SELECT, 2)]))
        else $error("almost full not following selected queue");

    chk_bus_assert: assert property ( // R17
        af_cmp[1] |-> ##2 !ALMOST_FULL_BUS[1])
        else $error("almost full bus bit late");

    chk_ov_tristate: assert property ( // R20
        $past(RST_B) |-> OUTPUT_VALID_N_OE == $past(id_match))
        else $error("output valid enable not following id match");

    chk_strap_take: assert property ( // R14
        $rose(strap_done) |-> strap_val == $past(DEFAULT_OFFSET_SELECT))
        else $error("offset strap not captured");

    cov_first_write: cover property (wr_q[rq] && count[rq] == 20'h00000 ##2 !OUTPUT_VALID_N_O);
    cov_full: cover property (fills[WRITE_QUEUE_SELECT] ##1 !FULL_FLAG_N);
    cov_paf: cover property ($fell(ALMOST_FULL_N));

endmodule

// *** tb/mq_ctrl_model.sv ***
// Write-side and read-side controller model that faces the flag generator.
`timescale 1ns/1ps
module mq_ctrl_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Requests and flags
    input  wire logic wr_go,
    input  wire logic rd_go,
    input  wire logic full_n,
    input  wire logic valid_n,
    // Strobes
    output logic      we,
    output logic      re
);
    // Writes stop on a full flag; reads wait for valid data and never run back to back.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            we <= 1'b0;
            re <= 1'b0;
        end else begin
            we <= wr_go & full_n;
            re <= rd_go & ~valid_n & ~re;
        end
    end
endmodule

// *** tb/multiqueue_flag_boundaries_test.sv ***
// Self-checking testbench for the multi-queue flag generator.
`timescale 1ns/1ps
module multiqueue_flag_boundaries_test;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        wr_go = 1'b0;
    logic        rd_go = 1'b0;
    logic        we, re, ov_o, ov_oe, ff_n, af_n;
    logic [1:0]  wq = 2'h0;
    logic [4:0]  rq = 5'h00;
    logic [2:0]  eid = 3'h0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wd = 32'h0;
    logic        rwr = 1'b0;
    logic        rrd = 1'b0;
    logic [31:0] rdata, wc, h1, h2;
    logic [3:0]  afb_n;
    logic        pf, almost_full_n, prr;
    logic        dsel = 1'b0;
    logic [31:0] q_full[$], q_af[$], q_reg[$];
    int          n_fail = 0;
    int          checks = 0;
    int          cyc = 0;
    int          i;
    int          seed = 32'h073e19c4;
    // Mode, read port on the queue at first write, full count and almost-full count (D=6, m=2).
    logic [4:0]  tm[7] = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h04, 5'h08, 5'h10};
    logic        tp[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [31:0] tf[7] = '{32'h7, 32'h6, 32'hE, 32'hC, 32'h1C, 32'h6, 32'h6};
    logic [31:0] ta[7] = '{32'h5, 32'h4, 32'hA, 32'hA, 32'h14, 32'h4, 32'h4};

    always #25 mclk = ~mclk;

    multiqueue_flags DUT (
        .MCLK(mclk), .RST_B(rst_b), .WRITE_ENABLE(we), .WRITE_QUEUE_SELECT(wq),
        .READ_ENABLE(re), .READ_QUEUE_SELECT(rq), .EXPANSION_ID_INPUT(eid),
        .DEFAULT_OFFSET_SELECT(dsel), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(rwr),
        .REG_RD(rrd), .REG_RDATA(rdata), .OUTPUT_VALID_N_O(ov_o), .OUTPUT_VALID_N_OE(ov_oe),
        .FULL_FLAG_N(ff_n), .ALMOST_FULL_N(af_n), .ALMOST_FULL_BUS(afb_n)
    );

    mq_ctrl_model partner (
        .clk(mclk), .rst_b(rst_b), .wr_go(wr_go), .rd_go(rd_go),
        .full_n(ff_n), .valid_n(ov_o), .we(we), .re(re)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // A read notes its expected word; the watcher compares it in the following cycle.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        if (!w) begin
            q_reg.push_back(d);
        end
        rwr <= w;
        rrd <= !w;
        addr <= a;
        wd <= d;
        @(posedge mclk);
        rwr <= 1'b0;
        rrd <= 1'b0;
    endtask

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (6) @(posedge mclk);
        dsel <= 1'($random(seed));
        rst_b <= 1'b1;
    endtask

    // Watcher: counts taken writes and compares each falling edge of the full and almost-full flags with the oldest note.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            $display("mismatch at %0t: run did not finish", $time);
            end_sim();
        end
        if (prr) cmp(rdata, q_reg.pop_front());
        if (pf && !ff_n) cmp(wc, q_full.pop_front());
        if (almost_full_n && !af_n) cmp(h2, q_af.pop_front());
        prr = rrd;
        pf = ff_n;
        almost_full_n = af_n;
        h2 = h1;
        h1 = wc;
        if (!rst_b) begin
            wc = 32'h0;
        end else if (we && ff_n) begin
            wc++;
        end
    end

    initial begin
        for (i = 0; i < 7; i++) begin
            do_reset();
            bus(1'b0, 4'h0, 32'h41);
            bus(1'b0, 4'h2, 32'h100);
            bus(1'b0, 4'h1, {19'h0, dsel, 12'h0});
            bus(1'b1, 4'h0, {26'h0, tp[i], tm[i]});
            bus(1'b1, 4'h7, 32'h2);
            bus(1'b1, 4'h3, 32'h6);
            bus(1'b1, 4'hE, $random(seed));
            bus(1'b0, 4'hE, 32'h0);
            bus(1'b0, 4'h0, {26'h0, tp[i], tm[i]});
            rq <= {4'h0, tp[i]};
            wq <= 2'h1;
            q_full.push_back(tf[i]);
            q_af.push_back(ta[i]);
            wr_go <= 1'b1;
            while (ff_n !== 1'b0) @(posedge mclk);
            wr_go <= 1'b0;
            repeat (3) @(posedge mclk);
            cmp(afb_n, 4'hD);
            if (i == 0) begin
                rd_go <= 1'b1;
                do @(posedge mclk); while (re !== 1'b1);
                rd_go <= 1'b0;
                #1 cmp(ff_n, 1'b0);
                @(posedge mclk) #1 cmp(ff_n, 1'b1);
                @(posedge mclk) wq <= 2'h0;
                @(posedge mclk) #1 cmp(af_n, 1'b0);
                repeat (2) @(posedge mclk);
                #1 cmp(af_n, 1'b1);
            end
            $display("test full boundaries mode %h done", tm[i]);
        end
        do_reset();
        rq <= 5'h00;
        wq <= 2'h0;
        @(posedge mclk) wr_go <= 1'b1;
        @(posedge mclk) wr_go <= 1'b0;
        @(posedge mclk) #1 cmp(ov_o, 1'b1);
        @(posedge mclk) #1 cmp(ov_o, 1'b0);
        @(posedge mclk) #1 cmp(ov_o, 1'b0);
        cmp(ov_oe, 1'b1);
        @(posedge mclk) rd_go <= 1'b1;
        @(posedge mclk) rd_go <= 1'b0;
        @(posedge mclk) #1 cmp(ov_o, 1'b1);
        @(posedge mclk) eid <= 3'(1 + {$random(seed)} % 7);
        @(posedge mclk) #1 cmp(ov_oe, 1'b0);
        $display("test output valid done");
        end_sim();
    end
endmodule
